//--- src/irq_steer_pkg.sv
package irq_steer_pkg;

  // Shared request lines and slots.
  localparam int unsigned SHARED_LINES = 4;
  localparam int unsigned SLOT_COUNT   = 3;
  localparam int unsigned SLOT_PINS    = 4;
  localparam int unsigned IRQ_LINES    = 16;
  localparam int unsigned SEL_WIDTH    = 3;

  // Indices of the shared request lines.
  localparam int unsigned SHARED_A = 0;
  localparam int unsigned SHARED_B = 1;
  localparam int unsigned SHARED_C = 2;
  localparam int unsigned SHARED_D = 3;

  // Rotation of each slot's pins onto the shared lines.
  localparam int unsigned SLOT1_ROTATE = 0;
  localparam int unsigned SLOT2_ROTATE = 1;
  localparam int unsigned SLOT3_ROTATE = 2;

  // Fixed system IRQ numbers.
  localparam int unsigned IRQ_TIMER    = 0;
  localparam int unsigned IRQ_KEYBOARD = 1;
  localparam int unsigned IRQ_CASCADE  = 2;
  localparam int unsigned IRQ_RTC      = 8;
  localparam int unsigned IRQ_FPU      = 13;

  // Steering choice: code to system IRQ number.
  localparam logic [3:0] STEER_IRQ [8] = '{
    4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hB, 4'hE, 4'hF
  };

  // Mask of system IRQs a shared line may reach.
  localparam logic [15:0] STEERABLE_MASK = 16'hCAB8;

  // Reset value of the per-line enables: all lines off.
  localparam logic [3:0] ENABLE_RESET = 4'h0;

endpackage

//--- src/irq_line_merge.sv
`timescale 1ns/1ps
`default_nettype none
module irq_line_merge
  import irq_steer_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 reset,
  // Active-high request per shared line.
  input  wire logic [3:0]           line_active,
  input  wire logic [3:0]           line_enable,
  input  wire logic [4*SEL_WIDTH-1:0] line_select,
  // Merged steered requests on system IRQ numbers.
  output logic      [15:0]          steered_q
);

  logic [15:0] steered_d;

  always_comb begin
    steered_d = 16'h0000;
    for (int i = 0; i < SHARED_LINES; i++) begin
      if (line_enable[i] && line_active[i]) begin
        steered_d[STEER_IRQ[line_select[i*SEL_WIDTH +: SEL_WIDTH]]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      steered_q <= 16'h0000;
    end else begin
      steered_q <= steered_d;
    end
  end

  a_steer_legal: assert property (@(posedge clock) disable iff (reset)
    (steered_q & ~STEERABLE_MASK) == 16'h0000)
    else $error("steered request on a non steerable IRQ");

endmodule
`default_nettype wire

//--- src/pci_interrupt_steering.sv
`timescale 1ns/1ps
`default_nettype none
module pci_interrupt_steering
  import irq_steer_pkg::*;
(
  // Clock and reset.
  input  wire logic                   clock,
  input  wire logic                   reset,
  // Slot interrupt pins, active low, pin A in bit 0.
  input  wire logic [3:0]             slot1_int_n,
  input  wire logic [3:0]             slot2_int_n,
  input  wire logic [3:0]             slot3_int_n,
  // Onboard sources, active low.
  input  wire logic                   video_inta_n,
  input  wire logic                   video_intb_n,
  input  wire logic                   usb_inta_n,
  input  wire logic                   lan_inta_n,
  // Steering controls.
  input  wire logic [3:0]             steer_enable,
  input  wire logic [4*SEL_WIDTH-1:0] steer_select,
  // ISA device requests, active high, and ISA ownership of each IRQ.
  input  wire logic [15:0]            isa_irq,
  input  wire logic [15:0]            isa_owned,
  // Fixed system resources.
  input  wire logic                   timer_irq,
  input  wire logic                   keyboard_full,
  input  wire logic                   cascade_irq,
  input  wire logic                   rtc_irq,
  input  wire logic                   fpu_error,
  input  wire logic                   io_channel_check,
  // Outputs to the legacy irq controller.
  output logic      [15:0]            system_irq_q,
  output logic                        nmi_q,
  output logic      [3:0]             shared_pci_request_n_q,
  output logic                        steer_conflict_q
);

  logic [3:0]  shared_pci_request_n;
  logic [3:0]  line_active;
  logic [3:0]  enable_d;
  logic [3:0]  enable_q;
  logic [15:0] steered_q;
  logic [15:0] fixed_irq;
  logic [15:0] steer_owned;
  logic [15:0] irq_d;
  logic        conflict_d;
  logic [3:0]  req_d;

  always_comb begin
    shared_pci_request_n = 4'hF;
    for (int p = 0; p < SLOT_PINS; p++) begin
      shared_pci_request_n[(p + SLOT1_ROTATE) % SHARED_LINES] &= slot1_int_n[p];
      shared_pci_request_n[(p + SLOT2_ROTATE) % SHARED_LINES] &= slot2_int_n[p];
      shared_pci_request_n[(p + SLOT3_ROTATE) % SHARED_LINES] &= slot3_int_n[p];
    end
    shared_pci_request_n[SHARED_B] &= video_inta_n;
    shared_pci_request_n[SHARED_C] &= video_intb_n;
    shared_pci_request_n[SHARED_C] &= lan_inta_n;
    shared_pci_request_n[SHARED_D] &= usb_inta_n;
    line_active = ~shared_pci_request_n;
  end

  // Block lines aimed at owned IRQs.
  always_comb begin
    steer_owned = 16'h0000;
    enable_d    = ENABLE_RESET;
    conflict_d  = 1'b0;
    for (int i = 0; i < SHARED_LINES; i++) begin
      if (steer_enable[i]) begin
        steer_owned[STEER_IRQ[steer_select[i*SEL_WIDTH +: SEL_WIDTH]]] = 1'b1;
      end
    end
    for (int i = 0; i < SHARED_LINES; i++) begin
      if (steer_enable[i] &&
          !isa_owned[STEER_IRQ[steer_select[i*SEL_WIDTH +: SEL_WIDTH]]]) begin
        enable_d[i] = 1'b1;
      end
    end
    conflict_d = |(steer_owned & isa_owned);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      enable_q <= ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  irq_line_merge u_merge (
    .clock       (clock),
    .reset       (reset),
    .line_active (line_active),
    .line_enable (enable_q),
    .line_select (steer_select),
    .steered_q   (steered_q)
  );

  always_comb begin
    fixed_irq               = 16'h0000;
    fixed_irq[IRQ_TIMER]    = timer_irq;
    fixed_irq[IRQ_KEYBOARD] = keyboard_full;
    fixed_irq[IRQ_CASCADE]  = cascade_irq;
    fixed_irq[IRQ_RTC]      = rtc_irq;
    fixed_irq[IRQ_FPU]      = fpu_error;
    irq_d = fixed_irq | (isa_irq & isa_owned & STEERABLE_MASK) |
            (isa_irq & isa_owned & ~STEERABLE_MASK & ~fixed_mask()) |
            (steered_q & STEERABLE_MASK);
    req_d = shared_pci_request_n;
  end

  function automatic logic [15:0] fixed_mask();
    logic [15:0] m;
    m = 16'h0000;
    m[IRQ_TIMER]    = 1'b1;
    m[IRQ_KEYBOARD] = 1'b1;
    m[IRQ_CASCADE]  = 1'b1;
    m[IRQ_RTC]      = 1'b1;
    m[IRQ_FPU]      = 1'b1;
    return m;
  endfunction

  always_ff @(posedge clock) begin
    if (reset) begin
      system_irq_q           <= 16'h0000;
      nmi_q                  <= 1'b0;
      shared_pci_request_n_q <= 4'hF;
      steer_conflict_q       <= 1'b0;
    end else begin
      system_irq_q           <= irq_d;
      nmi_q                  <= io_channel_check;
      shared_pci_request_n_q <= req_d;
      steer_conflict_q       <= conflict_d;
    end
  end

  a_slot1_straight: assert property (@(posedge clock) disable iff (reset)
    !slot1_int_n[0] |=> !shared_pci_request_n_q[SHARED_A])
    else $error("slot one pin A did not reach line A");

  a_slot2_rotate: assert property (@(posedge clock) disable iff (reset)
    !slot2_int_n[0] |=> !shared_pci_request_n_q[SHARED_B])
    else $error("slot two pin A did not reach line B");

  a_slot2_wrap: assert property (@(posedge clock) disable iff (reset)
    !slot2_int_n[3] |=> !shared_pci_request_n_q[SHARED_A])
    else $error("slot two pin D did not reach line A");

  a_slot3_rotate: assert property (@(posedge clock) disable iff (reset)
    !slot3_int_n[0] |=> !shared_pci_request_n_q[SHARED_C])
    else $error("slot three pin A did not reach line C");

  a_slot3_wrap: assert property (@(posedge clock) disable iff (reset)
    !slot3_int_n[3] |=> !shared_pci_request_n_q[SHARED_B])
    else $error("slot three pin D did not reach line B");

  a_video_line: assert property (@(posedge clock) disable iff (reset)
    !video_inta_n |=> !shared_pci_request_n_q[SHARED_B])
    else $error("video pin A did not reach line B");

  a_lan_line: assert property (@(posedge clock) disable iff (reset)
    !lan_inta_n |=> !shared_pci_request_n_q[SHARED_C])
    else $error("LAN request did not reach line C");

  a_usb_line: assert property (@(posedge clock) disable iff (reset)
    !usb_inta_n |=> !shared_pci_request_n_q[SHARED_D])
    else $error("USB request did not reach line D");

  a_shared_release: assert property (@(posedge clock) disable iff (reset)
    &slot1_int_n && &slot2_int_n && &slot3_int_n && video_inta_n && video_intb_n &&
    usb_inta_n && lan_inta_n |=> &shared_pci_request_n_q)
    else $error("shared line low with every source idle");

  a_fixed_timer: assert property (@(posedge clock) disable iff (reset)
    system_irq_q[IRQ_TIMER] == $past(timer_irq) && system_irq_q[IRQ_RTC] == $past(rtc_irq))
    else $error("fixed IRQ not driven");

  a_fixed_others: assert property (@(posedge clock) disable iff (reset)
    system_irq_q[IRQ_KEYBOARD] == $past(keyboard_full) &&
    system_irq_q[IRQ_CASCADE] == $past(cascade_irq) &&
    system_irq_q[IRQ_FPU] == $past(fpu_error))
    else $error("keyboard, cascade or coprocessor IRQ not driven");

  a_nmi_follow: assert property (@(posedge clock) disable iff (reset)
    nmi_q == $past(io_channel_check))
    else $error("NMI does not follow channel check");

  a_level_held: assert property (@(posedge clock) disable iff (reset)
    enable_q[SHARED_A] && !shared_pci_request_n[SHARED_A] && $stable(steer_select)
    ##1 enable_q[SHARED_A] && !shared_pci_request_n[SHARED_A] && $stable(steer_select)
    |=> system_irq_q[STEER_IRQ[$past(steer_select[SEL_WIDTH-1:0])]])
    else $error("steered line A not held");

  a_owned_block: assert property (@(posedge clock) disable iff (reset)
    steer_enable[SHARED_A] && isa_owned[STEER_IRQ[steer_select[SEL_WIDTH-1:0]]]
    |=> !enable_q[SHARED_A])
    else $error("line steered onto owned IRQ");

  a_conflict_flag: assert property (@(posedge clock) disable iff (reset)
    steer_conflict_q == $past(|(steer_owned & isa_owned)))
    else $error("sharing conflict not flagged");

endmodule
`default_nettype wire

//--- tb/pci_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module pci_source_model (
  // Source requests, active high: slot pins in 11:0, onboard in 15:12.
  input  wire logic [15:0] request,
  // Slot pins, pin A in bit 0.
  output logic      [3:0]  slot1_int_n,
  output logic      [3:0]  slot2_int_n,
  output logic      [3:0]  slot3_int_n,
  // Onboard sources.
  output logic             video_inta_n,
  output logic             video_intb_n,
  output logic             usb_inta_n,
  output logic             lan_inta_n
);
  assign slot1_int_n  = ~request[3:0];
  assign slot2_int_n  = ~request[7:4];
  assign slot3_int_n  = ~request[11:8];
  assign video_inta_n = ~request[12];
  assign video_intb_n = ~request[13];
  assign usb_inta_n   = ~request[14];
  assign lan_inta_n   = ~request[15];
endmodule
`default_nettype wire

//--- tb/pci_interrupt_steering_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pci_interrupt_steering_tb import irq_steer_pkg::*;;
  logic                   clock = 1'b0;
  logic                   reset = 1'b1;
  logic [15:0]            request = 16'h0000;
  logic [3:0]             steer_enable = 4'h0;
  logic [4*SEL_WIDTH-1:0] steer_select = 12'h000;
  logic [15:0]            isa_irq = 16'h0000;
  logic [15:0]            isa_owned = 16'h0000;
  logic [5:0]             fixed = 6'h00;
  logic [3:0]             s1_n, s2_n, s3_n;
  logic                   va_n, vb_n, usb_n, lan_n;
  logic [15:0]            system_irq_q;
  logic                   nmi_q;
  logic [3:0]             shared_n_q;
  logic                   conflict_q;
  int                     n_fail = 0;
  int                     checks_done = 0;
  int                     cycles = 0;

  always #12.5 clock = ~clock;

  pci_source_model i_src (.request(request), .slot1_int_n(s1_n), .slot2_int_n(s2_n),
    .slot3_int_n(s3_n), .video_inta_n(va_n), .video_intb_n(vb_n), .usb_inta_n(usb_n),
    .lan_inta_n(lan_n));

  pci_interrupt_steering i_dut (.clock(clock), .reset(reset), .slot1_int_n(s1_n),
    .slot2_int_n(s2_n), .slot3_int_n(s3_n), .video_inta_n(va_n), .video_intb_n(vb_n),
    .usb_inta_n(usb_n), .lan_inta_n(lan_n), .steer_enable(steer_enable),
    .steer_select(steer_select), .isa_irq(isa_irq), .isa_owned(isa_owned),
    .timer_irq(fixed[0]), .keyboard_full(fixed[1]), .cascade_irq(fixed[2]),
    .rtc_irq(fixed[3]), .fpu_error(fixed[4]), .io_channel_check(fixed[5]),
    .system_irq_q(system_irq_q), .nmi_q(nmi_q), .shared_pci_request_n_q(shared_n_q),
    .steer_conflict_q(conflict_q));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      stop_test();
    end
  end

  // Drives the sources, then lets every pipeline stage settle.
  task automatic apply(input logic [15:0] req);
    @(posedge clock);
    request <= req;
    repeat (4) @(posedge clock);
    #1;
  endtask

  function automatic logic [15:0] low(input int n);
    return {12'h000, ~(4'h1 << n)};
  endfunction

  task automatic t_slots;
    for (int s = 0; s < 3; s++) begin
      for (int p = 0; p < 4; p++) begin
        apply(16'h0001 << (4 * s + p));
        check("slot line", 16'(shared_n_q), low((p + s) % 4));
      end
    end
  endtask

  task automatic t_onboard;
    int ob_line [4] = '{1, 2, 3, 2};
    for (int i = 0; i < 4; i++) begin
      apply(16'h1000 << i);
      check("onboard line", 16'(shared_n_q), low(ob_line[i]));
    end
  endtask

  task automatic t_steer;
    @(posedge clock);
    steer_enable <= 4'h1;
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      steer_select <= 12'(k);
      apply(16'h0001);
      check("steered", system_irq_q, 16'h0001 << STEER_IRQ[k]);
    end
    apply(16'h0000);
    check("released", system_irq_q, 16'h0000);
  endtask

  task automatic t_merge;
    logic [15:0] seq [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0002, 16'h0000};
    @(posedge clock);
    steer_enable <= 4'h3;
    steer_select <= 12'h01B;
    for (int k = 0; k < 5; k++) begin
      apply(seq[k]);
      check("merged", system_irq_q, (k < 4) ? 16'h0080 : 16'h0000);
    end
  endtask

  task automatic t_fixed;
    int fix_irq [5] = '{IRQ_TIMER, IRQ_KEYBOARD, IRQ_CASCADE, IRQ_RTC, IRQ_FPU};
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      fixed <= 6'h01 << i;
      apply(16'h0000);
      check("fixed irq", system_irq_q, 16'h0001 << fix_irq[i]);
    end
    @(posedge clock);
    fixed <= 6'h20;
    apply(16'h0000);
    check("nmi", 16'(nmi_q), 16'h0001);
    check("nmi irq", system_irq_q, 16'h0000);
  endtask

  task automatic t_isa;
    @(posedge clock);
    fixed <= 6'h00;
    isa_owned <= 16'h0020;
    isa_irq <= 16'h0220;
    steer_enable <= 4'h1;
    steer_select <= 12'h002;
    apply(16'h0000);
    check("isa irq", system_irq_q, 16'h0020);
    check("conflict", 16'(conflict_q), 16'h0001);
    @(posedge clock);
    isa_irq <= 16'h0000;
    apply(16'h0001);
    check("blocked", system_irq_q, 16'h0000);
    check("shared", 16'(shared_n_q), 16'h000E);
  endtask

  initial begin
    repeat (4) @(posedge clock);
    #1;
    check("reset irq", system_irq_q, 16'h0000);
    check("reset shared", 16'(shared_n_q), 16'h000F);
    check("reset conflict", 16'(conflict_q), 16'h0000);
    @(posedge clock);
    reset <= 1'b0;
    t_slots();
    t_onboard();
    t_steer();
    t_merge();
    t_fixed();
    t_isa();
    stop_test();
  end
endmodule
`default_nettype wire
